// >>> ecpr_consts.vh
/*
 * Constants for the exception configuration and priority register bank:
 * register offsets, field positions, reset values and masks.
 * Assumes it is included by bare name from the design file.
 */
`ifndef ECPR_CONSTS_VH
`define ECPR_CONSTS_VH

// ****************************************************
// Register offsets
// ****************************************************
`define ECPR_OFF_CFG        8'h14
`define ECPR_OFF_FLTPRI     8'h18
`define ECPR_OFF_SVCPRI     8'h1C
`define ECPR_OFF_TICKPRI    8'h20

// ****************************************************
// Configuration fields and reset value
// ****************************************************
`define ECPR_CFG_THREAD     0
`define ECPR_CFG_UNPRIV     1
`define ECPR_CFG_MISAL      3
`define ECPR_CFG_DIVZ       4
`define ECPR_CFG_BFIGN      8
`define ECPR_CFG_STKAL      9
`define ECPR_CFG_MASK       32'h0000031B
`define ECPR_CFG_RESET      32'h00000200
`define ECPR_PRI_RESET      32'h00000000

// ****************************************************
// Priority field layout
// ****************************************************
`define ECPR_PRI_HI_MASK    8'hF0
`define ECPR_FLTPRI_MASK    32'h00F0F0F0
`define ECPR_SVCPRI_MASK    32'hF0000000
`define ECPR_TICKPRI_MASK   32'hF0F00000
`define ECPR_PSW_ALIGN_BIT  9

// ****************************************************
// Bus responses
// ****************************************************
`define ECPR_RESP_OKAY      2'b00
`define ECPR_RESP_SLVERR    2'b10

`endif

// >>> ecpr_regs.v
/*
 * Exception configuration and system handler priority register bank,
 * an AXI4-Lite slave, plus the core-side decisions those bits steer.
 * Assumes a single 200 MHz clock, synchronous active-low reset, and that
 * the core presents its event qualifiers on the same clock.
 */
`timescale 1ns/1ps
`include "ecpr_consts.vh"

module ecpr_regs (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Core event qualifiers
    input  wire [31:0] stack_pointer,
    input  wire        exc_entry,
    input  wire        exception_return_value,
    input  wire [31:0] stacked_psw,
    input  wire        handler_pri_neg,
    input  wire        data_bus_fault,
    input  wire        divide_exec,
    input  wire [31:0] divisor,
    input  wire        access_exec,
    input  wire        access_misaligned,
    input  wire        access_halfword_word,
    input  wire        access_multi_or_dword,
    input  wire        trigger_access,
    input  wire        trigger_unpriv,
    input  wire        thread_return_req,
    input  wire        other_exc_active,
    // Core decisions
    output reg  [31:0] entry_stack_pointer,
    output reg         entry_align_pad,
    output reg         return_align_pad,
    output reg         bus_fault_ignored,
    output reg         lockup,
    output reg         divide_fault,
    output reg         divide_zero_result,
    output reg         usage_fault_misaligned,
    output reg         trigger_allowed,
    output reg         trigger_denied,
    output reg         thread_entry_ok,
    output reg         thread_entry_fault,
    // Configuration and priorities for the core
    output reg  [31:0] cfg_out,
    output reg  [7:0]  memmanage_fault_priority,
    output reg  [7:0]  bus_fault_priority,
    output reg  [7:0]  usage_fault_priority,
    output reg  [7:0]  supervisor_call_priority_field,
    output reg  [7:0]  pendable_service_priority_field,
    output reg  [7:0]  system_tick_priority_field
);

    // ****************************************************
    // Register storage
    // ****************************************************
    reg  [31:0] thread_and_trap_config_r;
    reg  [31:0] fault_handler_priority_r;
    reg  [31:0] supervisor_call_priority_r;
    reg  [31:0] tick_and_pendable_priority_r;
    reg  [7:0]  awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         aw_held_r;
    reg         w_held_r;

    // Merge byte lanes of new data into old, keeping only implemented bits
    function [31:0] ecpr_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        input [31:0] mask;
        integer i;
        reg [31:0] res;
        begin
            res = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    res[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
            ecpr_merge = res & mask;
        end
    endfunction

    // Read mux by word offset
    function [32:0] ecpr_read;
        input [7:0]  addr;
        input [31:0] cfg_v;
        input [31:0] flt_v;
        input [31:0] svc_v;
        input [31:0] tick_v;
        begin
            case ({addr[7:2], 2'b00})
                `ECPR_OFF_CFG:     ecpr_read = {1'b1, cfg_v};
                `ECPR_OFF_FLTPRI:  ecpr_read = {1'b1, flt_v};
                `ECPR_OFF_SVCPRI:  ecpr_read = {1'b1, svc_v};
                `ECPR_OFF_TICKPRI: ecpr_read = {1'b1, tick_v};
                default:           ecpr_read = 33'h000000000;
            endcase
        end
    endfunction

    // ****************************************************
    // Write channel: address and data taken in either order
    // ****************************************************
    wire        aw_take = s_axi_awvalid & s_axi_awready;
    wire        w_take  = s_axi_wvalid & s_axi_wready;
    wire        aw_have = aw_held_r | aw_take;
    wire        w_have  = w_held_r | w_take;
    wire        do_wr   = aw_have & w_have & ~s_axi_bvalid;
    wire [7:0]  wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
    wire [7:0]  wr_word = {wr_addr[7:2], 2'b00};
    wire [32:0] rd_word = ecpr_read(s_axi_araddr, thread_and_trap_config_r,
                                    fault_handler_priority_r,
                                    supervisor_call_priority_r,
                                    tick_and_pendable_priority_r);

    // Write handshake, register update and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ECPR_RESP_OKAY;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            thread_and_trap_config_r     <= `ECPR_CFG_RESET;
            fault_handler_priority_r     <= `ECPR_PRI_RESET;
            supervisor_call_priority_r   <= `ECPR_PRI_RESET;
            tick_and_pendable_priority_r <= `ECPR_PRI_RESET;
        end else begin
            s_axi_awready <= ~aw_have & ~s_axi_bvalid;
            s_axi_wready  <= ~w_have & ~s_axi_bvalid;
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `ECPR_RESP_OKAY;
                case (wr_word)
                    `ECPR_OFF_CFG: begin
                        thread_and_trap_config_r <= ecpr_merge(
                            thread_and_trap_config_r, wr_data, wr_strb,
                            `ECPR_CFG_MASK);
                    end
                    `ECPR_OFF_FLTPRI: begin
                        fault_handler_priority_r <= ecpr_merge(
                            fault_handler_priority_r, wr_data, wr_strb,
                            `ECPR_FLTPRI_MASK);
                    end
                    `ECPR_OFF_SVCPRI: begin
                        supervisor_call_priority_r <= ecpr_merge(
                            supervisor_call_priority_r, wr_data, wr_strb,
                            `ECPR_SVCPRI_MASK);
                    end
                    `ECPR_OFF_TICKPRI: begin
                        tick_and_pendable_priority_r <= ecpr_merge(
                            tick_and_pendable_priority_r, wr_data, wr_strb,
                            `ECPR_TICKPRI_MASK);
                    end
                    default: begin
                        s_axi_bresp <= `ECPR_RESP_SLVERR;
                    end
                endcase
            end else begin
                aw_held_r <= aw_have;
                w_held_r  <= w_have;
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ****************************************************
    // Read channel
    // ****************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ECPR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word[31:0];
                s_axi_rresp  <= rd_word[32] ? `ECPR_RESP_OKAY : `ECPR_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************
    // Core decisions steered by the configuration bits
    // ****************************************************
    wire cfg_stkal  = thread_and_trap_config_r[`ECPR_CFG_STKAL];
    wire cfg_bfign  = thread_and_trap_config_r[`ECPR_CFG_BFIGN];
    wire cfg_divz   = thread_and_trap_config_r[`ECPR_CFG_DIVZ];
    wire cfg_misal  = thread_and_trap_config_r[`ECPR_CFG_MISAL];
    wire cfg_unpriv = thread_and_trap_config_r[`ECPR_CFG_UNPRIV];
    wire cfg_thread = thread_and_trap_config_r[`ECPR_CFG_THREAD];
    wire pad_needed = cfg_stkal & stack_pointer[2];
    wire div_zero   = divide_exec & (divisor == 32'h00000000);

    // Registered decision outputs, one cycle after the qualifier
    always @(posedge aclk) begin
        if (!aresetn) begin
            entry_stack_pointer    <= 32'h00000000;
            entry_align_pad        <= 1'b0;
            return_align_pad       <= 1'b0;
            bus_fault_ignored      <= 1'b0;
            lockup                 <= 1'b0;
            divide_fault           <= 1'b0;
            divide_zero_result     <= 1'b0;
            usage_fault_misaligned <= 1'b0;
            trigger_allowed        <= 1'b0;
            trigger_denied         <= 1'b0;
            thread_entry_ok        <= 1'b0;
            thread_entry_fault     <= 1'b0;
        end else begin
            // Align to 8 bytes when selected, otherwise word alignment
            entry_stack_pointer <= cfg_stkal ? {stack_pointer[31:3], 3'b000}
                                             : {stack_pointer[31:2], 2'b00};
            entry_align_pad  <= exc_entry & pad_needed;
            return_align_pad <= exception_return_value & stacked_psw[`ECPR_PSW_ALIGN_BIT];
            bus_fault_ignored <= data_bus_fault & handler_pri_neg & cfg_bfign;
            // Lock-up holds until reset
            if (data_bus_fault && handler_pri_neg && !cfg_bfign) begin
                lockup <= 1'b1;
            end
            divide_fault       <= div_zero & cfg_divz;
            divide_zero_result <= div_zero & ~cfg_divz;
            usage_fault_misaligned <= access_exec & access_misaligned &
                                      (access_multi_or_dword |
                                       (access_halfword_word & cfg_misal));
            trigger_allowed <= trigger_access & (~trigger_unpriv | cfg_unpriv);
            trigger_denied  <= trigger_access & trigger_unpriv & ~cfg_unpriv;
            thread_entry_ok <= thread_return_req &
                               (cfg_thread | ~other_exc_active);
            thread_entry_fault <= thread_return_req & ~cfg_thread &
                                  other_exc_active;
        end
    end

    // Register contents for the core, split into priority fields
    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg_out                         <= `ECPR_CFG_RESET;
            memmanage_fault_priority        <= 8'h00;
            bus_fault_priority              <= 8'h00;
            usage_fault_priority            <= 8'h00;
            supervisor_call_priority_field  <= 8'h00;
            pendable_service_priority_field <= 8'h00;
            system_tick_priority_field      <= 8'h00;
        end else begin
            cfg_out                         <= thread_and_trap_config_r;
            memmanage_fault_priority        <= fault_handler_priority_r[7:0];
            bus_fault_priority              <= fault_handler_priority_r[15:8];
            usage_fault_priority            <= fault_handler_priority_r[23:16];
            supervisor_call_priority_field  <= supervisor_call_priority_r[31:24];
            pendable_service_priority_field <= tick_and_pendable_priority_r[23:16];
            system_tick_priority_field      <= tick_and_pendable_priority_r[31:24];
        end
    end

endmodule // ecpr_regs

// >>> ecpr_regs_properties.sv
/*
 * Checker for the exception configuration and priority register bank.
 * Assumes one clock, a synchronous active-low reset and a bind to ecpr_regs.
 */
`timescale 1ns/1ps

module ecpr_regs_properties (
    // Clock, reset and bus handshakes
    input wire        aclk, aresetn,
    input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire        s_axi_bvalid, s_axi_rvalid, s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Core event qualifiers
    input wire [31:0] stack_pointer, stacked_psw, divisor,
    input wire        exc_entry, exception_return_value, handler_pri_neg, data_bus_fault,
    input wire        divide_exec, access_exec, access_misaligned,
    input wire        access_halfword_word, access_multi_or_dword,
    input wire        trigger_access, trigger_unpriv, thread_return_req, other_exc_active,
    // Core decisions and register copies
    input wire [31:0] entry_stack_pointer, cfg_out,
    input wire        return_align_pad, bus_fault_ignored, lockup,
    input wire        divide_fault, divide_zero_result, usage_fault_misaligned,
    input wire        trigger_allowed, trigger_denied, thread_entry_ok,
    input wire [7:0]  memmanage_fault_priority, bus_fault_priority, usage_fault_priority,
    input wire [7:0]  supervisor_call_priority_field, pendable_service_priority_field,
    input wire [7:0]  system_tick_priority_field
);
    // Helper bits so that past values are taken of whole signals
    wire psw_align = stacked_psw[9];
    wire div_zero  = (divisor == 32'h00000000);
    wire mis_hw    = access_exec & access_misaligned & access_halfword_word;
    wire mis_multi = access_exec & access_misaligned & access_multi_or_dword;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************************
    // Bus handshake steps
    // ****************************************************
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    a_write_answer: assert property (s_wr_both |=> s_axi_bvalid)
        else $error("write response missing after address and data");
    a_read_hold: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before acceptance");

    // ****************************************************
    // Core decisions against the configuration copy, then reserved bits of the register copies
    // ****************************************************
    a_stack_align: assert property ($past(aresetn) && $past(exc_entry) |->
        entry_stack_pointer == ($past(stack_pointer) & (cfg_out[9] ? 32'hFFFFFFF8 : 32'hFFFFFFFC)))
        else $error("entry stack pointer alignment wrong");
    a_return_align: assert property ($past(aresetn) |->
        return_align_pad == ($past(exception_return_value) && $past(psw_align)))
        else $error("return alignment pad wrong");
    a_bus_ignore: assert property ($past(aresetn) |-> bus_fault_ignored ==
        ($past(data_bus_fault) && $past(handler_pri_neg) && cfg_out[8]))
        else $error("bus fault ignore decision wrong");
    a_lockup_set: assert property ($past(aresetn) && $past(data_bus_fault)
        && $past(handler_pri_neg) && !cfg_out[8] |-> lockup ##1 lockup[*3])
        else $error("lockup not raised or not held");
    a_divide_gate: assert property ($past(aresetn) |->
        divide_fault == ($past(divide_exec) && $past(div_zero) && cfg_out[4])
        && divide_zero_result == ($past(divide_exec) && $past(div_zero) && !cfg_out[4]))
        else $error("divide by zero decision wrong");
    a_misalign_fault: assert property ($past(aresetn) |-> usage_fault_misaligned ==
        ($past(mis_multi) || ($past(mis_hw) && cfg_out[3])))
        else $error("misaligned access fault wrong");
    a_trigger_gate: assert property ($past(aresetn) && $past(trigger_access) |->
        trigger_allowed == (!$past(trigger_unpriv) || cfg_out[1]) && trigger_denied != trigger_allowed)
        else $error("trigger register access decision wrong");
    a_thread_gate: assert property ($past(aresetn) && $past(thread_return_req) |->
        thread_entry_ok == (cfg_out[0] || !$past(other_exc_active)))
        else $error("thread entry decision wrong");
    a_cfg_reserved: assert property ((cfg_out & 32'hFFFFFCE4) == 32'h00000000)
        else $error("reserved configuration bit set");
    a_pri_low_zero: assert property ({memmanage_fault_priority[3:0], bus_fault_priority[3:0],
        usage_fault_priority[3:0], supervisor_call_priority_field[3:0],
        pendable_service_priority_field[3:0], system_tick_priority_field[3:0]} == 24'h000000)
        else $error("priority low nibble not zero");
endmodule // ecpr_regs_properties

bind ecpr_regs ecpr_regs_properties u_props (.*);

// >>> ecpr_regs_tb.sv
/*
 * Self-checking bench for the exception configuration and priority bank.
 * Assumes ecpr_regs, its constants header and the bound checker.
 */
`timescale 1ns/1ps
`include "ecpr_consts.vh"

module ecpr_regs_tb;
    // Stimulus registers, all given a value at time zero
    reg         aclk = 1'b0, aresetn = 1'b0;
    reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg  [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    reg  [31:0] s_axi_wdata = 32'h0, stack_pointer = 32'h0, stacked_psw = 32'h0, divisor = 32'h1;
    reg  [3:0]  s_axi_wstrb = 4'h0;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg         exc_entry = 1'b0, exception_return_value = 1'b0, handler_pri_neg = 1'b0, data_bus_fault = 1'b0;
    reg         divide_exec = 1'b0, access_exec = 1'b0, access_misaligned = 1'b0;
    reg         access_halfword_word = 1'b0, access_multi_or_dword = 1'b0, trigger_access = 1'b0;
    reg         trigger_unpriv = 1'b0, thread_return_req = 1'b0, other_exc_active = 1'b0;
    // Design outputs
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, entry_stack_pointer, cfg_out;
    wire        entry_align_pad, return_align_pad, bus_fault_ignored, lockup, divide_fault;
    wire        divide_zero_result, usage_fault_misaligned, trigger_allowed, trigger_denied;
    wire        thread_entry_ok, thread_entry_fault;
    wire [7:0]  memmanage_fault_priority, bus_fault_priority, usage_fault_priority;
    wire [7:0]  supervisor_call_priority_field, pendable_service_priority_field;
    wire [7:0]  system_tick_priority_field;
    integer     errors = 0;
    integer     checked = 0;

    ecpr_regs dut (.*);

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    // ****************************************************
    // Comparison, bus and closing tasks
    // ****************************************************
    task chk_word(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD %0t word %h expected %h", $time, got, exp);
            end
        end
    endtask

    task chk_flag(input got, input exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD %0t flag %b expected %b", $time, got, exp);
            end
        end
    endtask

    task axi_wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
        integer n;
        begin
            @(posedge aclk);
            s_axi_awaddr  <= a;
            s_axi_wdata   <= d;
            s_axi_wstrb   <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                n = n + 1;
                if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1 && n < 40);
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            chk_flag(n < 40, 1'b1);
        end
    endtask

    task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
        integer n;
        begin
            @(posedge aclk);
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                n = n + 1;
                if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
                if (s_axi_arvalid === 1'b0) s_axi_rready <= 1'b1;
            end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 40);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            chk_flag(n < 40, 1'b1);
        end
    endtask

    task give_verdict;
        begin
            $display("checked %0d errors %0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    // Reset values, then all implemented configuration bits and an unmapped offset
    task t_reset_and_config;
        reg [31:0] d;
        reg [1:0]  r;
        begin
            axi_rd(`ECPR_OFF_CFG, d, r);
            chk_word(d, 32'h00000200);
            chk_word({30'h0, r}, 32'h00000000);
            chk_word(cfg_out, 32'h00000200);
            axi_rd(`ECPR_OFF_TICKPRI, d, r);
            chk_word(d, 32'h00000000);
            axi_wr(`ECPR_OFF_CFG, 32'h0000031B, 4'hF, r);
            chk_word({30'h0, r}, 32'h00000000);
            axi_rd(`ECPR_OFF_CFG, d, r);
            chk_word(d, 32'h0000031B);
            axi_wr(8'h24, 32'hFFFFFFFF, 4'hF, r);
            chk_word({30'h0, r}, 32'h00000002);
            axi_rd(8'h24, d, r);
            chk_word({d[29:0], r}, 32'h00000002);
        end
    endtask

    // Priority field masks, layout and byte lanes
    task t_priority;
        integer    i;
        reg [7:0]  a;
        reg [31:0] d, m;
        reg [1:0]  r;
        begin
            a = `ECPR_OFF_FLTPRI;
            for (i = 0; i < 3; i = i + 1) begin
                axi_rd(a, d, r);
                chk_word(d, 32'h00000000);
                axi_wr(a, 32'hFFFFFFFF, 4'hF, r);
                axi_rd(a, d, r);
                m = (i == 0) ? 32'h00F0F0F0 : (i == 1) ? 32'hF0000000 : 32'hF0F00000;
                chk_word(d, m);
                a = a + 8'h04;
            end
            axi_wr(`ECPR_OFF_FLTPRI, 32'h5A5A5A5A, 4'h2, r);
            axi_rd(`ECPR_OFF_FLTPRI, d, r);
            chk_word(d, 32'h00F050F0);
            axi_wr(`ECPR_OFF_TICKPRI, 32'h00000000, 4'h8, r);
            axi_rd(`ECPR_OFF_TICKPRI, d, r);
            chk_word(d, 32'h00F00000);
            chk_word({bus_fault_priority, usage_fault_priority, memmanage_fault_priority,
                      supervisor_call_priority_field}, 32'h50F0F0F0);
            chk_word({system_tick_priority_field, pendable_service_priority_field},
                     32'h000000F0);
        end
    endtask

    // All core decisions under three settings, then forced faults and lock-up
    task t_decisions;
        integer    i;
        reg [31:0] c;
        reg [1:0]  r;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                c = (i == 0) ? 32'h0000031B : (i == 1) ? 32'h00000200 : 32'h00000000;
                axi_wr(`ECPR_OFF_CFG, c, 4'hF, r);
                @(posedge aclk);
                stack_pointer <= 32'h20000FFC;
                stacked_psw <= 32'h00000200;
                divisor <= 32'h00000000;
                {access_misaligned, access_halfword_word, trigger_unpriv} <= 3'h7;
                {other_exc_active, handler_pri_neg, data_bus_fault} <= {2'h3, c[8]};
                {exc_entry, exception_return_value, divide_exec, access_exec} <= 4'hF;
                {trigger_access, thread_return_req} <= 2'h3;
                @(posedge aclk);
                {exc_entry, exception_return_value, divide_exec, access_exec} <= 4'h0;
                {trigger_access, thread_return_req, data_bus_fault} <= 3'h0;
                #1;
                chk_word(entry_stack_pointer, c[9] ? 32'h20000FF8 : 32'h20000FFC);
                chk_flag(entry_align_pad, c[9]);
                chk_flag(return_align_pad, 1'b1);
                chk_flag(bus_fault_ignored, c[8]);
                chk_flag(divide_fault, c[4]);
                chk_flag(divide_zero_result, ~c[4]);
                chk_flag(usage_fault_misaligned, c[3]);
                chk_flag(trigger_allowed, c[1]);
                chk_flag(trigger_denied, ~c[1]);
                chk_flag(thread_entry_ok, c[0]);
                chk_flag(thread_entry_fault, ~c[0]);
                chk_flag(lockup, 1'b0);
            end
            @(posedge aclk);
            {access_halfword_word, access_multi_or_dword} <= 2'h1;
            {access_exec, data_bus_fault} <= 2'h3;
            @(posedge aclk);
            {access_exec, data_bus_fault} <= 2'h0;
            #1;
            chk_flag(usage_fault_misaligned, 1'b1);
            chk_flag(bus_fault_ignored, 1'b0);
            repeat (3) @(posedge aclk);
            #1;
            chk_flag(lockup, 1'b1);
            // Reset in mid-run clears the sticky lock-up and restores the configuration reset value
            @(posedge aclk);
            aresetn <= 1'b0;
            @(posedge aclk);
            aresetn <= 1'b1;
            #1;
            chk_flag(lockup, 1'b0);
            chk_word(cfg_out, 32'h00000200);
        end
    endtask

    // Main sequence: reset held for three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_and_config;
        t_priority;
        t_decisions;
        give_verdict;
    end

    // Watchdog against a hung handshake
    initial begin
        #20000;
        errors = errors + 1;
        $display("BAD %0t watchdog expired", $time);
        give_verdict;
    end
endmodule // ecpr_regs_tb
